// ### design/mr_exec.sv
// Execution unit for store, literal load, no-operation and the two returns.
// Assumes the core's stack presents its top entry and pops on a one-cycle
// pulse, and that the file register space accepts a one-cycle write strobe.
//
// Contract
// - Store copies accumulator to file, flags kept.
// - Literal load puts immediate in accumulator.
// - Interrupt return pops stack into PC, two cycles.
// - Interrupt return sets global interrupt enable.
// - Literal return writes immediate to accumulator.
// - Literal return pops stack, two cycles.
module mr_exec #(
    parameter int CYCLE_DIV = mr_pkg::CYCLE_DIV
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Instruction fetch
    input mr_pkg::mr_instr_t instr,
    output logic instr_ready,
    output logic [mr_pkg::PC_W-1:0] pc,
    // Hardware stack
    input wire logic [mr_pkg::PC_W-1:0] top_of_stack_entry,
    output logic stack_pop,
    // File register write
    output mr_pkg::mr_fwrite_t file_write,
    // Accumulator and interrupt control
    output logic [mr_pkg::DATA_W-1:0] accumulator,
    input wire logic int_enable_clear,
    output logic global_interrupt_enable,
    // Status
    output logic instr_cycle,
    output logic retired,
    output logic unsupported
);

    localparam logic [mr_pkg::DIV_W-1:0] DIV_LAST = mr_pkg::DIV_W'(CYCLE_DIV - 1);

    mr_pkg::mr_state_t s_reg;
    mr_pkg::mr_state_t s_next;
    mr_pkg::mr_dec_t dec;
    logic cycle_en;

    // ==========================================================
    // Decoder
    // ==========================================================
    mr_decode i_mr_decode (
        .word(instr.word),
        .dec(dec)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    assign cycle_en = (s_reg.div == DIV_LAST);

    always_comb begin
        s_next = s_reg;
        s_next.fw.we = 1'b0;
        s_next.pop = 1'b0;
        s_next.retired = 1'b0;
        s_next.unsupported = 1'b0;
        if (cycle_en) begin
            s_next.div = '0;
        end else begin
            s_next.div = s_reg.div + 1'b1;
        end
        // A clear from interrupt entry; an interrupt return in the same cycle overrides it.
        if (int_enable_clear) begin
            s_next.int_en = 1'b0;
        end
        if (cycle_en) begin
            case (s_reg.phase)
                mr_pkg::MR_ST_EXEC: begin
                    if (instr.valid) begin
                        s_next.retired = 1'b1;
                        s_next.pc = s_reg.pc + 1'b1;
                        case (dec.op)
                            mr_pkg::MR_OP_STORE: begin
                                s_next.fw.we = 1'b1;
                                s_next.fw.addr = dec.faddr;
                                s_next.fw.data = s_reg.acc;
                            end
                            mr_pkg::MR_OP_LOADLIT: begin
                                s_next.acc = dec.literal;
                            end
                            mr_pkg::MR_OP_RETINT: begin
                                s_next.pc = top_of_stack_entry;
                                s_next.pop = 1'b1;
                                s_next.int_en = 1'b1;
                                s_next.phase = mr_pkg::MR_ST_FLUSH;
                            end
                            mr_pkg::MR_OP_RETLIT: begin
                                s_next.acc = dec.literal;
                                s_next.pc = top_of_stack_entry;
                                s_next.pop = 1'b1;
                                s_next.phase = mr_pkg::MR_ST_FLUSH;
                            end
                            mr_pkg::MR_OP_NOP: begin
                            end
                            default: begin
                                s_next.unsupported = 1'b1;
                            end
                        endcase
                    end
                end
                default: begin
                    // Second cycle of a return: the word fetched meanwhile is dropped.
                    s_next.phase = mr_pkg::MR_ST_EXEC;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg.phase <= mr_pkg::MR_ST_EXEC;
            s_reg.div <= '0;
            s_reg.pc <= mr_pkg::PC_RESET;
            s_reg.acc <= mr_pkg::ACC_RESET;
            s_reg.int_en <= mr_pkg::INT_ENABLE_RESET;
            s_reg.fw <= '0;
            s_reg.pop <= 1'b0;
            s_reg.retired <= 1'b0;
            s_reg.unsupported <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign instr_ready = cycle_en && (s_reg.phase == mr_pkg::MR_ST_EXEC);
    assign instr_cycle = cycle_en;
    assign pc = s_reg.pc;
    assign stack_pop = s_reg.pop;
    assign file_write = s_reg.fw;
    assign accumulator = s_reg.acc;
    assign global_interrupt_enable = s_reg.int_en;
    assign retired = s_reg.retired;
    assign unsupported = s_reg.unsupported;

endmodule

// ### design/mr_pkg.sv
// Shared constants and types for the move-and-return execution block.
// Assumes one clock (mclk) and a 14-bit instruction word fetched by the core.
package mr_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int WORD_W = 14;
    localparam int PC_W = 13;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;

    // ==========================================================
    // Timing
    // ==========================================================
    // Oscillator clocks per instruction cycle.
    localparam int CYCLE_DIV = 4;
    localparam int DIV_W = $clog2(CYCLE_DIV);

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic INT_ENABLE_RESET = 1'b0;
    // Position of the global interrupt enable in the interrupt control register.
    localparam int INT_ENABLE_BIT = 7;

    // ==========================================================
    // Opcode patterns, as mask and match
    // ==========================================================
    localparam logic [WORD_W-1:0] OP_STORE_MASK = 14'h3F80;
    localparam logic [WORD_W-1:0] OP_STORE_MATCH = 14'h0080;
    localparam logic [WORD_W-1:0] OP_LIT_MASK = 14'h3C00;
    localparam logic [WORD_W-1:0] OP_LOADLIT_MATCH = 14'h3000;
    localparam logic [WORD_W-1:0] OP_RETLIT_MATCH = 14'h3400;
    localparam logic [WORD_W-1:0] OP_NOP_MASK = 14'h3F9F;
    localparam logic [WORD_W-1:0] OP_NOP_MATCH = 14'h0000;
    localparam logic [WORD_W-1:0] OP_RETINT_MATCH = 14'h0009;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        MR_OP_NOP,
        MR_OP_STORE,
        MR_OP_LOADLIT,
        MR_OP_RETINT,
        MR_OP_RETLIT,
        MR_OP_OTHER
    } mr_op_t;

    typedef struct packed {
        mr_op_t op;
        logic [DATA_W-1:0] literal;
        logic [FADDR_W-1:0] faddr;
    } mr_dec_t;

    typedef struct packed {
        logic valid;
        logic [WORD_W-1:0] word;
    } mr_instr_t;

    typedef struct packed {
        logic we;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mr_fwrite_t;

    typedef enum logic [0:0] {
        MR_ST_EXEC,
        MR_ST_FLUSH
    } mr_phase_t;

    typedef struct packed {
        mr_phase_t phase;
        logic [DIV_W-1:0] div;
        logic [PC_W-1:0] pc;
        logic [DATA_W-1:0] acc;
        logic int_en;
        mr_fwrite_t fw;
        logic pop;
        logic retired;
        logic unsupported;
    } mr_state_t;

endpackage

// ### design/mr_decode.sv
// Combinational decoder for the move-and-return instruction group.
// Assumes the word is stable for the instruction cycle in which it is read.
module mr_decode (
    // Instruction word
    input wire logic [mr_pkg::WORD_W-1:0] word,
    // Decoded fields
    output mr_pkg::mr_dec_t dec
);

    // ==========================================================
    // Decode
    // ==========================================================
    // Unused literal-form bits are assembled as zeros, but the decoder masks
    // them out so that any value there still executes the same way.
    always_comb begin
        dec.literal = word[mr_pkg::DATA_W-1:0];
        dec.faddr = word[mr_pkg::FADDR_W-1:0];
        if ((word & mr_pkg::OP_STORE_MASK) == mr_pkg::OP_STORE_MATCH) begin
            dec.op = mr_pkg::MR_OP_STORE;
        end else if ((word & mr_pkg::OP_LIT_MASK) == mr_pkg::OP_LOADLIT_MATCH) begin
            dec.op = mr_pkg::MR_OP_LOADLIT;
        end else if ((word & mr_pkg::OP_LIT_MASK) == mr_pkg::OP_RETLIT_MATCH) begin
            dec.op = mr_pkg::MR_OP_RETLIT;
        end else if (word == mr_pkg::OP_RETINT_MATCH) begin
            dec.op = mr_pkg::MR_OP_RETINT;
        end else if ((word & mr_pkg::OP_NOP_MASK) == mr_pkg::OP_NOP_MATCH) begin
            dec.op = mr_pkg::MR_OP_NOP;
        end else begin
            dec.op = mr_pkg::MR_OP_OTHER;
        end
    end

endmodule

// ### test/mr_exec_assertions.sv
// Checker for the move-and-return execution unit.
// Assumes it is bound to mr_exec running with CYCLE_DIV of 4.
module mr_exec_chk #(
    parameter int CYCLE_DIV = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Observed ports
    input mr_pkg::mr_instr_t instr,
    input wire logic instr_ready,
    input wire logic [mr_pkg::PC_W-1:0] pc,
    input wire logic [mr_pkg::PC_W-1:0] top_of_stack_entry,
    input wire logic stack_pop,
    input mr_pkg::mr_fwrite_t file_write,
    input wire logic [mr_pkg::DATA_W-1:0] accumulator,
    input wire logic global_interrupt_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Properties
    // ==========================================================
    logic take;
    logic [13:0] w;
    assign take = instr_ready & instr.valid;
    assign w = instr.word;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_store_copy: assert property (
        take && (w & 14'h3F80) == 14'h0080 |=> file_write.we && file_write.addr == $past(w[6:0])
        && file_write.data == $past(accumulator) ##1 !file_write.we) else $error("store bad");
    a_loadlit_acc: assert property (
        take && w[13:10] == 4'hC |=> accumulator == $past(w[7:0]) && !stack_pop)
        else $error("load literal bad");
    a_retint_pop: assert property (
        take && w == 14'h0009 |=> stack_pop && pc == $past(top_of_stack_entry) ##1 !stack_pop)
        else $error("interrupt return pop bad");
    a_retint_enable: assert property (
        take && w == 14'h0009 |=> global_interrupt_enable) else $error("enable not set");
    a_retlit_acc: assert property (
        take && w[13:10] == 4'hD |=> accumulator == $past(w[7:0]) && stack_pop
        && pc == $past(top_of_stack_entry)) else $error("literal return bad");
    a_ret_flush: assert property (
        take && (w == 14'h0009 || w[13:10] == 4'hD) |=> !instr_ready [*7] ##1 instr_ready)
        else $error("return not two cycles");
    a_nop_only: assert property (
        take && w == 14'h0000 |=> pc == $past(pc) + 13'h0001 && $stable(accumulator)
        && !file_write.we && !stack_pop) else $error("nop bad");
    a_pc_hold: assert property (
        !take |=> $stable(pc)) else $error("pc moved without take");
endmodule

bind mr_exec mr_exec_chk #(.CYCLE_DIV(CYCLE_DIV)) i_mr_exec_chk (.mclk(mclk), .reset_n(reset_n),
    .instr(instr), .instr_ready(instr_ready), .pc(pc), .top_of_stack_entry(top_of_stack_entry),
    .stack_pop(stack_pop), .file_write(file_write), .accumulator(accumulator),
    .global_interrupt_enable(global_interrupt_enable));

// ### test/mr_exec_bench.sv
// Self-checking bench for the move-and-return execution unit.
// Assumes the checker file is compiled alongside and binds itself.
module mr_exec_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    mr_pkg::mr_instr_t instr = '0;
    logic [12:0] stack_top = 13'h0000;
    logic int_enable_clear = 1'b0;
    logic instr_ready, stack_pop, int_en, retired, unsupported;
    logic [12:0] pc;
    logic [7:0] acc;
    mr_pkg::mr_fwrite_t fw;
    logic [39:0] exp_q[$];
    logic [39:0] seen;
    logic [12:0] m_pc = 13'h0000;
    logic [7:0] m_acc = 8'h00;
    logic m_int_en = 1'b0;
    int n_fail = 0;
    int num_checks = 0;

    always #20 mclk = ~mclk;

    mr_exec #(.CYCLE_DIV(4)) i_mr_exec (.mclk(mclk), .reset_n(reset_n), .instr(instr),
        .instr_ready(instr_ready), .pc(pc), .top_of_stack_entry(stack_top),
        .stack_pop(stack_pop), .file_write(fw), .accumulator(acc),
        .int_enable_clear(int_enable_clear),
        .global_interrupt_enable(int_en), .instr_cycle(), .retired(retired),
        .unsupported(unsupported));

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic print_verdict();
        if (n_fail == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Each call lets one edge pass first, so that valid is never lowered and raised at once.
    // A stray store word is offered while not ready; it must be ignored.
    // Now and then the enable clear shares the take edge; an interrupt return still sets the enable.
    task automatic exec(input logic [13:0] word);
        logic we;
        logic pop;
        logic clr;
        logic oth;
        int i;
        @(negedge mclk);
        instr.valid = 1'b1;
        instr.word = 14'h0080 | 14'($urandom & 32'h7F);
        for (i = 0; i < 16 && instr_ready !== 1'b1; i++) @(negedge mclk);
        if (i == 16) begin
            n_fail++;
            print_verdict();
        end
        instr.word = word;
        clr = ($urandom & 32'h3) == 32'h0;
        int_enable_clear = clr;
        we = (word & 14'h3F80) == 14'h0080;
        pop = word == 14'h0009 || word[13:10] == 4'hD;
        oth = !(we || pop || word[13:11] == 3'h6 || word == 14'h0000);
        m_pc = pop ? stack_top : m_pc + 13'h0001;
        if (word[13:11] == 3'h6) m_acc = word[7:0];
        if (clr) m_int_en = 1'b0;
        if (word == 14'h0009) m_int_en = 1'b1;
        exp_q.push_back({m_pc, m_acc, m_int_en, we, we ? {word[6:0], m_acc} : 15'h0000,
            pop, oth});
        @(negedge mclk);
        instr.valid = 1'b0;
        int_enable_clear = 1'b0;
    endtask

    task automatic clear_int_en();
        @(negedge mclk);
        int_enable_clear = 1'b1;
        m_int_en = 1'b0;
        @(negedge mclk);
        int_enable_clear = 1'b0;
    endtask

    always @(negedge mclk) begin
        if (reset_n && retired === 1'b1) begin
            seen = {pc, acc, int_en, fw.we, fw.we ? {fw.addr, fw.data} : 15'h0000, stack_pop,
                unsupported};
            num_checks++;
            if (exp_q.size() == 0 ||
                seen !== exp_q[0]) begin
                n_fail++;
                $display("CHECK FAILED state exp %h seen %h", exp_q[0], seen);
            end
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
    end

    initial begin
        int n;
        logic [7:0] k;
        void'($urandom(67137));
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        exec(14'h30FF);
        exec(14'h00FF);
        exec(14'h0080);
        exec(14'h0000);
        for (n = 0; n < 40; n++) begin
            stack_top = 13'($urandom);
            k = 8'($urandom);
            case ($urandom_range(5))
                0: exec(14'h0080 | 14'(k[6:0]));
                1: exec(14'h3000 | 14'(k));
                2: exec(14'h0000);
                3: begin
                    clear_int_en();
                    exec(14'h0009);
                end
                4: exec(14'h0700 | 14'(k));
                default: exec(14'h3400 | 14'(k));
            endcase
        end
        repeat (8) @(negedge mclk);
        if (exp_q.size() != 0) n_fail++;
        // A second reset in mid-run must bring back the reset values.
        reset_n = 1'b0;
        m_pc = mr_pkg::PC_RESET;
        m_acc = mr_pkg::ACC_RESET;
        m_int_en = mr_pkg::INT_ENABLE_RESET;
        @(negedge mclk);
        num_checks++;
        if (pc !== m_pc || acc !== m_acc || int_en !== m_int_en) begin
            n_fail++;
            $display("CHECK FAILED reset exp %h %h %h seen %h %h %h", m_pc, m_acc, m_int_en,
                pc, acc, int_en);
        end
        reset_n = 1'b1;
        stack_top = 13'($urandom);
        exec(14'h3000 | 14'($urandom & 32'hFF));
        exec(14'h0009);
        exec(14'h0000);
        repeat (8) @(negedge mclk);
        if (exp_q.size() != 0) n_fail++;
        print_verdict();
    end
endmodule
